// ===== hdl/stfr_regs.sv
// Purpose: FIFO interrupt, multiframe subchannel and holdoff registers
// Assumes: Register port and loop-side inputs are on sys_clk
// Notes:   nt_mode_pin is a strap, synchronised before use
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module stfr_regs #(
	parameter logic [stfr_pkg::CNT_W-1:0] MF_CYCLES = stfr_pkg::MF_CYCLES
) (
	input  wire logic                          sys_clk,
	input  wire logic                          resetn,
	input  wire logic                          soft_rst,
	input  wire logic                          nt_mode_pin,
	input  wire logic [stfr_pkg::ADDR_W-1:0]   reg_addr,
	input  wire logic [stfr_pkg::DATA_W-1:0]   reg_wdata,
	input  wire logic                          reg_wr,
	input  wire logic                          reg_rd,
	output logic      [stfr_pkg::DATA_W-1:0]   reg_rdata,
	input  wire logic                          m_rx_valid,
	input  wire logic [7:0]                    m_rx_byte,
	input  wire logic                          a_rx_valid,
	input  wire logic [7:0]                    a_rx_byte,
	input  wire logic [15:0]                   sc_rx_nibbles,
	output logic      [15:0]                   sc_tx_nibbles,
	output logic                               mf_enable,
	output logic                               mf_start,
	output logic                               info1_holdoff,
	output logic                               info3_holdoff,
	output logic                               irq_n
);
	import stfr_pkg::*;

	// Mode strap
	logic mode_meta_ff;
	logic nt_ff;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			mode_meta_ff <= 1'b0;
			nt_ff        <= 1'b0;
		end else begin
			mode_meta_ff <= nt_mode_pin;
			nt_ff        <= mode_meta_ff;
		end
	end

	// Control registers
	logic [1:0]  fi_en_ff, nxt_fi_en;
	logic        mf_en_ff, nxt_mf_en;
	logic        ie_mf_ff, nxt_ie_mf;
	logic [1:0]  act_ff,   nxt_act;
	logic [15:0] sc_wr_ff, nxt_sc_wr;

	always_comb begin
		nxt_fi_en = fi_en_ff;
		nxt_mf_en = mf_en_ff;
		nxt_ie_mf = ie_mf_ff;
		nxt_act   = act_ff;
		nxt_sc_wr = sc_wr_ff;
		if (soft_rst) begin
			nxt_fi_en = 2'h0;
			nxt_mf_en = 1'b0;
			nxt_ie_mf = 1'b0;
			nxt_act   = 2'h0;
			nxt_sc_wr = RST_SC;
		end else if (reg_wr) begin
			case (reg_addr)
				ADR_FIFO_IRQ: begin
					nxt_fi_en = {reg_wdata[FI_A_EN],
						reg_wdata[FI_M_EN]};
				end
				ADR_LOOP_CFG: nxt_mf_en = reg_wdata[LC_MF_EN];
				ADR_IRQ_EN:   nxt_ie_mf = reg_wdata[IE_MF];
				ADR_ACT: begin
					nxt_act = {reg_wdata[ACT_NO_INFO1],
						reg_wdata[ACT_NO_INFO3]};
				end
				// Writes land any time in NT mode and are ignored in TE; only the next start samples them
				ADR_SC23: begin
					if (nt_ff) begin
						nxt_sc_wr[15:8] = reg_wdata;
					end
				end
				ADR_SC45: begin
					if (nt_ff) begin
						nxt_sc_wr[7:0] = reg_wdata;
					end
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			fi_en_ff <= 2'h0;
			mf_en_ff <= 1'b0;
			ie_mf_ff <= 1'b0;
			act_ff   <= 2'h0;
			sc_wr_ff <= RST_SC;
		end else begin
			fi_en_ff <= nxt_fi_en;
			mf_en_ff <= nxt_mf_en;
			ie_mf_ff <= nxt_ie_mf;
			act_ff   <= nxt_act;
			sc_wr_ff <= nxt_sc_wr;
		end
	end

	// Receive FIFO heads, one per channel
	logic [1:0] rx_vld;
	logic [7:0] rx_byte [2];
	logic [1:0] ch_full;
	logic [7:0] ch_byte [2];

	assign rx_vld     = {a_rx_valid, m_rx_valid};
	assign rx_byte[0] = m_rx_byte;
	assign rx_byte[1] = a_rx_byte;

	for (genvar ch = 0; ch < 2; ch++) begin : g_ch
		logic       rd_hit;
		logic       full_ff, nxt_full;
		logic [7:0] byte_ff, nxt_byte;

		assign rd_hit = reg_rd &&
			(reg_addr == ((ch == 0) ? ADR_M_FIFO : ADR_A_FIFO));

		// A byte arriving while full is dropped to keep the head intact, unless the head is read in the same cycle
		always_comb begin
			nxt_full = full_ff;
			nxt_byte = byte_ff;
			if (soft_rst) begin
				nxt_full = 1'b0;
				nxt_byte = RST_BYTE;
			end else begin
				if (rd_hit) begin
					nxt_full = 1'b0;
				end
				if (rx_vld[ch] && (!full_ff || rd_hit)) begin
					nxt_full = 1'b1;
					nxt_byte = rx_byte[ch];
				end
			end
		end

		always_ff @(posedge sys_clk or negedge resetn) begin
			if (!resetn) begin
				full_ff <= 1'b0;
				byte_ff <= RST_BYTE;
			end else begin
				full_ff <= nxt_full;
				byte_ff <= nxt_byte;
			end
		end

		assign ch_full[ch] = full_ff;
		assign ch_byte[ch] = byte_ff;
	end

	// Multiframe timer
	stfr_mf_if mf_bus ();

	assign mf_bus.run = mf_en_ff;

	stfr_mf_timer #(
		.CYCLES (MF_CYCLES)
	) u_timer (
		.sys_clk  (sys_clk),
		.resetn   (resetn),
		.soft_rst (soft_rst),
		.mf       (mf_bus.timer)
	);

	// Subchannel nibbles and multiframe pending flag
	logic [15:0] sc_tx_ff,   nxt_sc_tx;
	logic [15:0] sc_rx_ff,   nxt_sc_rx;
	logic        mf_pend_ff, nxt_mf_pend;

	always_comb begin
		nxt_sc_tx   = sc_tx_ff;
		nxt_sc_rx   = sc_rx_ff;
		nxt_mf_pend = mf_pend_ff;
		if (soft_rst) begin
			nxt_sc_tx   = RST_SC;
			nxt_sc_rx   = RST_SC;
			nxt_mf_pend = 1'b0;
		end else begin
			if (reg_rd && reg_addr == ADR_MF_STAT) begin
				nxt_mf_pend = 1'b0;
			end
			if (mf_bus.start) begin
				nxt_mf_pend = 1'b1;
				// Held until the next start, so old values repeat
				if (nt_ff) begin
					nxt_sc_tx = sc_wr_ff;
				end else begin
					nxt_sc_rx = sc_rx_nibbles;
				end
			end
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			sc_tx_ff   <= RST_SC;
			sc_rx_ff   <= RST_SC;
			mf_pend_ff <= 1'b0;
		end else begin
			sc_tx_ff   <= nxt_sc_tx;
			sc_rx_ff   <= nxt_sc_rx;
			mf_pend_ff <= nxt_mf_pend;
		end
	end

	// Order on the wire: SC2, SC3, SC4, SC5, each MSB first
	assign sc_tx_nibbles = sc_tx_ff;
	assign mf_enable     = mf_en_ff;
	assign mf_start      = mf_bus.start;

	// Holdoffs only mean something on the network side
	assign info1_holdoff = nt_ff & act_ff[1];
	assign info3_holdoff = nt_ff & act_ff[0];

	assign irq_n = !(|(ch_full & fi_en_ff)
		| (mf_pend_ff & ie_mf_ff));

	// Read data
	logic [7:0] rdata_ff, nxt_rdata;

	always_comb begin
		nxt_rdata = RST_BYTE;
		if (reg_rd) begin
			case (reg_addr)
				ADR_M_FIFO: nxt_rdata = ch_byte[0];
				ADR_A_FIFO: nxt_rdata = ch_byte[1];
				ADR_LOOP_CFG: nxt_rdata[LC_MF_EN] = mf_en_ff;
				ADR_FIFO_IRQ: begin
					nxt_rdata[FI_M_FLAG] = ch_full[0];
					nxt_rdata[FI_A_FLAG] = ch_full[1];
					nxt_rdata[FI_M_EN]   = fi_en_ff[0];
					nxt_rdata[FI_A_EN]   = fi_en_ff[1];
				end
				// Write-only in NT mode, so reads give zero there
				ADR_SC23: begin
					if (!nt_ff) begin
						nxt_rdata = sc_rx_ff[15:8];
					end
				end
				ADR_SC45: begin
					if (!nt_ff) begin
						nxt_rdata = sc_rx_ff[7:0];
					end
				end
				ADR_ACT: begin
					nxt_rdata[ACT_NO_INFO1] = act_ff[1];
					nxt_rdata[ACT_NO_INFO3] = act_ff[0];
				end
				ADR_IRQ_EN:  nxt_rdata[IE_MF] = ie_mf_ff;
				ADR_MF_STAT: nxt_rdata[MS_MF_PEND] = mf_pend_ff;
				default:     nxt_rdata = RST_BYTE;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rdata_ff <= RST_BYTE;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign reg_rdata = rdata_ff;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	chk_m_irq_pin: assert property (ch_full[0] && fi_en_ff[0]
		|-> !irq_n)
		else $error("enabled M flag left pin high");
	chk_m_irq_hold: assert property (ch_full[0] && fi_en_ff[0]
		&& !(reg_rd && reg_addr == ADR_M_FIFO) && !soft_rst
		&& !(reg_wr && reg_addr == ADR_FIFO_IRQ)
		|=> !irq_n)
		else $error("pin released before M read");
	chk_mask_block: assert property (fi_en_ff == 2'h0
		&& !ie_mf_ff |-> irq_n)
		else $error("masked source drove pin");
	chk_mask_write: assert property (reg_wr
		&& reg_addr == ADR_FIFO_IRQ && !soft_rst
		|=> fi_en_ff[0] == $past(reg_wdata[FI_M_EN])
		&& fi_en_ff[1] == $past(reg_wdata[FI_A_EN]))
		else $error("mask bits not written");
	chk_a_set: assert property (a_rx_valid && !ch_full[1]
		&& !soft_rst |=> ch_full[1] && ch_byte[1] == $past(a_rx_byte))
		else $error("A byte not captured");
	chk_a_clear: assert property (reg_rd
		&& reg_addr == ADR_A_FIFO && !a_rx_valid |=> !ch_full[1])
		else $error("A read left flag set");
	chk_m_set: assert property (m_rx_valid && !ch_full[0]
		&& !soft_rst |=> ch_full[0] && ch_byte[0] == $past(m_rx_byte))
		else $error("M byte not captured");
	chk_m_clear: assert property (reg_rd
		&& reg_addr == ADR_M_FIFO && !m_rx_valid |=> !ch_full[0])
		else $error("M read left flag set");
	chk_soft_clear: assert property (soft_rst
		|=> ch_full == 2'h0 && sc_tx_ff == RST_SC)
		else $error("soft reset left state");
	chk_sc_sample: assert property (mf_bus.start && nt_ff
		&& !soft_rst |=> sc_tx_ff == $past(sc_wr_ff))
		else $error("NT nibbles not sampled");
	chk_sc_stable: assert property (!mf_bus.start
		&& !soft_rst |=> $stable(sc_tx_ff) && $stable(sc_rx_ff))
		else $error("nibbles changed mid multiframe");
	chk_mf_irq: assert property (mf_bus.start && ie_mf_ff
		&& !soft_rst && !(reg_wr && reg_addr == ADR_IRQ_EN)
		|=> !irq_n)
		else $error("no multiframe interrupt");
	chk_te_load: assert property (mf_bus.start && !nt_ff
		&& !soft_rst |=> sc_rx_ff == $past(sc_rx_nibbles))
		else $error("TE nibbles not loaded");
	chk_holdoff_nt: assert property (reg_wr
		&& reg_addr == ADR_ACT && !soft_rst
		|=> info1_holdoff == (nt_ff && $past(reg_wdata[ACT_NO_INFO1]))
		&& info3_holdoff == (nt_ff && $past(reg_wdata[ACT_NO_INFO3])))
		else $error("holdoff not following register");

	cov_m_irq: cover property (ch_full[0] && fi_en_ff[0] ##1
		reg_rd && reg_addr == ADR_M_FIFO);
	cov_nt_mf: cover property (mf_bus.start && nt_ff);
	cov_te_mf: cover property (mf_bus.start && !nt_ff);
	cov_set_clear: cover property (m_rx_valid && ch_full[0]
		&& reg_rd && reg_addr == ADR_M_FIFO);
endmodule

// ===== inc/stfr_pkg.sv
// Purpose: Shared constants for the S/T control and status registers
// Assumes: 8-bit register port, 200 MHz sys_clk
// Notes:   Channel index 0 is the M channel, 1 is the A channel
package stfr_pkg;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 8;

	// Register offsets
	localparam logic [4:0] ADR_M_FIFO   = 5'h00;
	localparam logic [4:0] ADR_A_FIFO   = 5'h01;
	localparam logic [4:0] ADR_LOOP_CFG = 5'h07;
	localparam logic [4:0] ADR_FIFO_IRQ = 5'h08;
	localparam logic [4:0] ADR_SC23     = 5'h09;
	localparam logic [4:0] ADR_SC45     = 5'h0a;
	localparam logic [4:0] ADR_ACT      = 5'h0b;
	localparam logic [4:0] ADR_IRQ_EN   = 5'h14;
	localparam logic [4:0] ADR_MF_STAT  = 5'h15;

	// Field positions
	localparam int FI_M_FLAG    = 0;
	localparam int FI_A_FLAG    = 1;
	localparam int FI_M_EN      = 2;
	localparam int FI_A_EN      = 3;
	localparam int LC_MF_EN     = 5;
	localparam int IE_MF        = 2;
	localparam int MS_MF_PEND   = 0;
	localparam int ACT_NO_INFO3 = 6;
	localparam int ACT_NO_INFO1 = 7;

	// Reset values
	localparam logic [7:0]  RST_BYTE = 8'h00;
	localparam logic [15:0] RST_SC   = 16'h0000;

	// Multiframe timing
	localparam int MF_TIME_US = 5000;
	localparam int CLK_MHZ    = 200;
	localparam int CNT_W      = 20;
	localparam logic [19:0] MF_CYCLES = 20'(MF_TIME_US * CLK_MHZ);

	typedef enum logic {STFR_MF_IDLE, STFR_MF_RUN} stfr_mf_state_t;
endpackage

// ===== inc/stfr_mf_if.sv
// Purpose: Link between register bank and multiframe timer
// Assumes: Both ends on sys_clk
// Notes:   start is a one-cycle pulse from a flop
`timescale 1ns/1ps
interface stfr_mf_if;
	logic run;
	logic start;
	modport ctrl  (output run, input start);
	modport timer (input run, output start);
endinterface

// ===== hdl/stfr_mf_timer.sv
// Purpose: Multiframe start pulse generator
// Assumes: run comes from a register on sys_clk
// Notes:   First pulse marks the start of the first multiframe
`timescale 1ns/1ps
module stfr_mf_timer #(
	parameter logic [stfr_pkg::CNT_W-1:0] CYCLES = stfr_pkg::MF_CYCLES
) (
	input  wire logic sys_clk,
	input  wire logic resetn,
	input  wire logic soft_rst,
	stfr_mf_if.timer  mf
);
	import stfr_pkg::*;

	stfr_mf_state_t   state_ff, nxt_state;
	logic [CNT_W-1:0] cnt_ff,   nxt_cnt;
	logic             start_ff, nxt_start;

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		nxt_start = 1'b0;
		case (state_ff)
			STFR_MF_IDLE: begin
				if (mf.run) begin
					nxt_state = STFR_MF_RUN;
					nxt_cnt   = '0;
					nxt_start = 1'b1;
				end
			end
			STFR_MF_RUN: begin
				if (!mf.run) begin
					nxt_state = STFR_MF_IDLE;
				end else if (cnt_ff == CYCLES - 1'b1) begin
					nxt_cnt   = '0;
					nxt_start = 1'b1;
				end else begin
					nxt_cnt = cnt_ff + 1'b1;
				end
			end
			default: nxt_state = STFR_MF_IDLE;
		endcase
		if (soft_rst) begin
			nxt_state = STFR_MF_IDLE;
			nxt_cnt   = '0;
			nxt_start = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state_ff <= STFR_MF_IDLE;
			cnt_ff   <= '0;
			start_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
			start_ff <= nxt_start;
		end
	end

	assign mf.start = start_ff;

	// Pulses come no closer than nine cycles apart unless run drops and rises again between them
	chk_mf_spacing: assert property (@(posedge sys_clk)
		disable iff (!resetn) start_ff |=> (!start_ff) [*8])
		else $error("multiframe starts too close");
endmodule

// ===== tb/stfr_link_model.sv
// Purpose: Far-side model feeding link bytes and received subchannels
// Assumes: Driven from the bench through its tasks, on sys_clk
// Notes:   Byte lines show the inverse value once released
`timescale 1ns/1ps
module stfr_link_model (
	input  wire logic        sys_clk,
	output logic             m_rx_valid,
	output logic [7:0]       m_rx_byte,
	output logic             a_rx_valid,
	output logic [7:0]       a_rx_byte,
	output logic [15:0]      sc_rx_nibbles
);
	initial begin
		m_rx_valid = 1'b0;
		a_rx_valid = 1'b0;
		m_rx_byte = 8'h00;
		a_rx_byte = 8'h00;
		sc_rx_nibbles = 16'h0000;
	end

	// Channel 0 is M, 1 is A; idle gives a slow sender
	task automatic put_byte(input logic ch, input logic [7:0] b,
			input int idle);
		repeat (idle) @(posedge sys_clk);
		@(posedge sys_clk);
		m_rx_valid <= ~ch;
		a_rx_valid <= ch;
		if (ch) a_rx_byte <= b;
		else m_rx_byte <= b;
		@(posedge sys_clk);
		m_rx_valid <= 1'b0;
		a_rx_valid <= 1'b0;
		// Stale data would hide a late sample
		if (ch) a_rx_byte <= ~b;
		else m_rx_byte <= ~b;
	endtask

	task automatic set_sc(input logic [15:0] v);
		@(posedge sys_clk);
		sc_rx_nibbles <= v;
	endtask
endmodule

// ===== tb/st_fifo_irq_multiframe_regs_tb.sv
// Purpose: Self-checking bench for the S/T register bank
// Assumes: Multiframe shortened to 16 cycles
// Notes:   Runs NT first, then TE after a soft reset
`timescale 1ns/1ps
module st_fifo_irq_multiframe_regs_tb;
	import stfr_pkg::*;
	localparam logic [CNT_W-1:0] MF_N = 20'd16;
	logic        sys_clk = 1'b0;
	logic        resetn = 1'b0;
	logic        soft_rst = 1'b0;
	logic        nt_mode_pin = 1'b1;
	logic [4:0]  reg_addr = 5'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [7:0]  reg_rdata;
	logic        m_rx_valid;
	logic [7:0]  m_rx_byte;
	logic        a_rx_valid;
	logic [7:0]  a_rx_byte;
	logic [15:0] sc_rx_nibbles;
	logic [15:0] sc_tx_nibbles;
	logic        mf_enable;
	logic        mf_start;
	logic        info1_holdoff;
	logic        info3_holdoff;
	logic        irq_n;
	int          num_errors = 0;
	int          samples_checked = 0;
	int          cyc = 0;
	int          t0;
	logic [7:0]  hv [3] = '{8'h80, 8'h40, 8'hc0};

	always #2.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) cyc <= cyc + 1;

	stfr_regs #(.MF_CYCLES(MF_N)) dut (
		.sys_clk(sys_clk), .resetn(resetn), .soft_rst(soft_rst),
		.nt_mode_pin(nt_mode_pin), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .m_rx_valid(m_rx_valid),
		.m_rx_byte(m_rx_byte), .a_rx_valid(a_rx_valid),
		.a_rx_byte(a_rx_byte), .sc_rx_nibbles(sc_rx_nibbles),
		.sc_tx_nibbles(sc_tx_nibbles), .mf_enable(mf_enable),
		.mf_start(mf_start), .info1_holdoff(info1_holdoff),
		.info3_holdoff(info3_holdoff), .irq_n(irq_n)
	);

	stfr_link_model model (
		.sys_clk(sys_clk), .m_rx_valid(m_rx_valid),
		.m_rx_byte(m_rx_byte), .a_rx_valid(a_rx_valid),
		.a_rx_byte(a_rx_byte), .sc_rx_nibbles(sc_rx_nibbles)
	);

	task automatic chk_val(input string what, input logic [15:0] exp,
			input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_bit(input string what, input logic exp, input logic got);
		chk_val(what, {15'h0, exp}, {15'h0, got});
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [4:0] a, input logic [7:0] exp,
			input string what);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		chk_val(what, {8'h00, exp}, {8'h00, reg_rdata});
	endtask

	// Bounded wait, well past one multiframe
	task automatic wait_mf;
		int n;
		n = 0;
		do begin
			@(posedge sys_clk);
			#1;
			n++;
		end while (mf_start !== 1'b1 && n < 40);
		chk_bit("mf_start", 1'b1, mf_start);
	endtask

	task automatic soft_pulse;
		@(posedge sys_clk);
		soft_rst <= 1'b1;
		@(posedge sys_clk);
		soft_rst <= 1'b0;
		#1;
	endtask

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", samples_checked,
			num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		#(3000 * 5);
		num_errors++;
		final_report;
	end

	initial begin
		repeat (6) @(posedge sys_clk);
		resetn <= 1'b1;
		#1;
		chk_bit("irq_n reset", 1'b1, irq_n);
		chk_bit("mf_enable reset", 1'b0, mf_enable);
		rd(ADR_FIFO_IRQ, 8'h00, "fifo_irq reset");
		wr(ADR_FIFO_IRQ, 8'h0c);
		rd(ADR_FIFO_IRQ, 8'h0c, "masks");
		model.put_byte(1'b0, 8'h5a, 0);
		#1;
		chk_bit("irq_n m", 1'b0, irq_n);
		rd(ADR_FIFO_IRQ, 8'h0d, "m flag");
		chk_bit("irq_n held", 1'b0, irq_n);
		rd(ADR_M_FIFO, 8'h5a, "m data");
		chk_bit("irq_n m clr", 1'b1, irq_n);
		model.put_byte(1'b1, 8'hc3, 2);
		#1;
		chk_bit("irq_n a", 1'b0, irq_n);
		rd(ADR_FIFO_IRQ, 8'h0e, "a flag");
		rd(ADR_A_FIFO, 8'hc3, "a data");
		chk_bit("irq_n a clr", 1'b1, irq_n);
		wr(ADR_FIFO_IRQ, 8'h08);
		model.put_byte(1'b0, 8'h81, 0);
		#1;
		chk_bit("irq_n masked", 1'b1, irq_n);
		rd(ADR_FIFO_IRQ, 8'h09, "masked flag");
		rd(ADR_M_FIFO, 8'h81, "m data 2");
		model.put_byte(1'b1, 8'h7e, 0);
		soft_pulse();
		chk_bit("irq_n soft", 1'b1, irq_n);
		rd(ADR_FIFO_IRQ, 8'h00, "fifo_irq soft");
		for (int i = 0; i < 3; i++) begin
			wr(ADR_ACT, hv[i]);
			#1;
			chk_bit("info1_holdoff", hv[i][7], info1_holdoff);
			chk_bit("info3_holdoff", hv[i][6], info3_holdoff);
			rd(ADR_ACT, hv[i], "holdoff reg");
		end
		wr(ADR_SC23, 8'h12);
		wr(ADR_SC45, 8'h34);
		rd(ADR_SC23, 8'h00, "sc23 nt read");
		wr(ADR_IRQ_EN, 8'h04);
		wr(ADR_LOOP_CFG, 8'h20);
		#1;
		chk_bit("mf_enable", 1'b1, mf_enable);
		wait_mf();
		t0 = cyc;
		@(posedge sys_clk);
		#1;
		chk_val("sc_tx", 16'h1234, sc_tx_nibbles);
		chk_val("sc45 tx", 16'h0034, {8'h00, sc_tx_nibbles[7:0]});
		chk_bit("irq_n mf", 1'b0, irq_n);
		wr(ADR_SC23, 8'hab);
		#1;
		chk_val("sc_tx held", 16'h1234, sc_tx_nibbles);
		rd(ADR_MF_STAT, 8'h01, "mf pending");
		chk_bit("irq_n mf clr", 1'b1, irq_n);
		rd(ADR_LOOP_CFG, 8'h20, "loop cfg");
		wait_mf();
		chk_val("mf period", MF_N[15:0], 16'(cyc - t0));
		@(posedge sys_clk);
		#1;
		chk_val("sc_tx next", 16'hab34, sc_tx_nibbles);
		@(posedge sys_clk);
		nt_mode_pin <= 1'b0;
		model.set_sc(16'hc3e7);
		soft_pulse();
		chk_bit("mf_enable soft", 1'b0, mf_enable);
		repeat (3) @(posedge sys_clk);
		rd(ADR_SC23, 8'h00, "sc23 te reset");
		wr(ADR_SC23, 8'hff);
		wr(ADR_LOOP_CFG, 8'h20);
		wait_mf();
		@(posedge sys_clk);
		rd(ADR_SC23, 8'hc3, "sc23 te");
		rd(ADR_SC45, 8'he7, "sc45 te");
		chk_val("sc_tx te", 16'h0000, sc_tx_nibbles);
		wr(ADR_ACT, 8'hc0);
		#1;
		chk_bit("info1 te", 1'b0, info1_holdoff);
		final_report;
	end
endmodule
